// ===== sim/tcou_port_model.sv
// Partner: general port pin with output value and direction
`timescale 1ns/1ps
module tcou_port_model (
  // Clock
  input wire logic aclk,
  // Settings from the bench
  input wire logic [1:0] set_value,
  input wire logic [1:0] set_dir,
  // Port side of the unit
  output logic [1:0] port_out_value,
  output logic [1:0] compare_pin_direction_bit,
  input wire logic [1:0] compare_output_pin,
  input wire logic [1:0] compare_output_pin_oe,
  // Pad level
  output logic [1:0] pad
);
  logic [1:0] last_q;
  assign port_out_value = set_value;
  assign compare_pin_direction_bit = set_dir;
  always_ff @(posedge aclk) begin
    last_q <= pad;
  end
  // No pull on the pad: an undriven pad keeps flipping, never holds
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pad[i] = compare_output_pin_oe[i] ? compare_output_pin[i] : ~last_q[i];
    end
  end
endmodule

// ===== sim/tcou_properties.sv
// Checker: bus handshake and pin enable properties of the compare unit
`timescale 1ns/1ps
module tcou_properties
  import tcou_pkg::*;
#(
  parameter int NCH = TCOU_NCH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [NCH-1:0] compare_pin_direction_bit,
  input wire logic [NCH-1:0] compare_output_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_OE_DIR: assert property (compare_output_pin_oe == compare_pin_direction_bit)
    else $error("pin enable differs from direction bit");
  AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  AST_BRESP_CODE: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
    else $error("illegal write response code");
endmodule
bind tcou_top tcou_properties #(.NCH(NCH)) i_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .compare_pin_direction_bit, .compare_output_pin_oe);

// ===== sim/timer_compare_output_unit_tb.sv
// Testbench: register, pin and waveform checks of the compare unit
`timescale 1ns/1ps
module timer_compare_output_unit_tb;
  import tcou_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_bresp;
  logic [31:0] s_axi_rdata, v;
  logic [1:0] set_value = 2'b00, set_dir = 2'b11, port_out_value, compare_pin_direction_bit;
  logic [1:0] compare_output_pin, compare_output_pin_oe, pad;
  logic [34:0] expq[$];
  logic [34:0] qe;
  int n_mismatch = 0, cmp_count = 0, n, hi, bad;
  int sh[5] = '{0, 3, 6, 8, 10};
  always #4 aclk = ~aclk;
  tcou_top #(.NCH(2)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_out_value, .compare_pin_direction_bit,
    .compare_output_pin, .compare_output_pin_oe, .irq);
  tcou_port_model i_port (.aclk, .set_value, .set_dir, .port_out_value,
    .compare_pin_direction_bit, .compare_output_pin, .compare_output_pin_oe, .pad);
  ////////////////////////////////////////
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        dd = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // Read data is judged by the watcher below, in issue order
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
    input bit care);
    expq.push_back({care, r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    v = s_axi_rdata;
    s_axi_rready <= 0;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && expq.size() > 0) begin
      qe = expq.pop_front();
      chk("rresp", 32'(qe[33:32]), 32'(s_axi_rresp));
      if (qe[34]) chk("rdata", qe[31:0], s_axi_rdata);
    end
  end
  task pins(input logic [1:0] e);
    repeat (2) @(posedge aclk);
    chk("pins", 32'(e), 32'(compare_output_pin));
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    test_done();
  end
  initial begin
    void'($urandom(43768));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    set_value <= 2'($urandom());
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 0, 2'b00, 1);
    rd(8'h3C, 0, 2'b10, 0);
    wr(8'h3C, 1);
    chk("bresp", 32'h2, 32'(last_bresp));
    pins(set_value);
    chk("pad", 32'(set_value), 32'(pad));
    $display("test reset done");
    wr(TCOU_OFF_OUTSTATE, 3);
    pins(set_value);
    wr(TCOU_OFF_CTRL_A, 32'h9);
    pins(2'b11);
    set_dir <= 2'b01;
    repeat (2) @(posedge aclk);
    chk("pad a", 1, 32'(pad[0]));
    chk("oe", 1, 32'(compare_output_pin_oe));
    set_dir <= 2'b11;
    wr(TCOU_OFF_COUNT, 32'h0011);
    wr(TCOU_OFF_CTRL_C, 3);
    pins(2'b00);
    rd(TCOU_OFF_CTRL_C, 0, 2'b00, 1);
    rd(TCOU_OFF_STATUS, 0, 2'b00, 1);
    rd(TCOU_OFF_COUNT, 32'h0011, 2'b00, 1);
    wr(TCOU_OFF_CTRL_A, 32'hF);
    wr(TCOU_OFF_CTRL_C, 3);
    pins(2'b11);
    $display("test override and force done");
    n = 20 + $urandom() % 40;
    wr(TCOU_OFF_CMP_A, n);
    wr(TCOU_OFF_CMP_B, n);
    wr(TCOU_OFF_CTRL_A, 1);
    wr(TCOU_OFF_OUTSTATE, 0);
    wr(TCOU_OFF_CTRL_B, 1);
    repeat (100) @(posedge aclk);
    rd(TCOU_OFF_STATUS, 3, 2'b00, 1);
    rd(TCOU_OFF_OUTSTATE, 1, 2'b00, 1);
    pins({set_value[1], 1'b1});
    chk("irq masked", 0, 32'(irq));
    wr(TCOU_OFF_MASK, 1);
    pins({set_value[1], 1'b1});
    chk("irq", 1, 32'(irq));
    wr(TCOU_OFF_STATUS, 1);
    rd(TCOU_OFF_STATUS, 2, 2'b00, 1);
    chk("irq clear", 0, 32'(irq));
    wr(TCOU_OFF_CTRL_A, 2);
    pins({set_value[1], 1'b1});
    $display("test match done");
    for (int m = 2; m <= 3; m++) begin
      wr(TCOU_OFF_CTRL_B, 0);
      wr(TCOU_OFF_COUNT, 0);
      wr(TCOU_OFF_CMP_A, 0);
      wr(TCOU_OFF_CMP_B, 32'h00FF);
      wr(TCOU_OFF_CTRL_A, m * 5);
      wr(TCOU_OFF_CTRL_B, 32'h09);
      repeat (600) @(posedge aclk);
      bad = 0;
      repeat (600) @(posedge aclk) bad += (compare_output_pin !== (m == 2 ? 2'b10 : 2'b01));
      chk("steady level", 0, bad);
    end
    wr(TCOU_OFF_CTRL_B, 32'h08);
    wr(TCOU_OFF_COUNT, 0);
    wr(TCOU_OFF_CMP_A, 32'h00FF);
    wr(TCOU_OFF_CTRL_B, 32'h09);
    pins(2'b01);
    repeat (600) @(posedge aclk);
    pins(2'b00);
    $display("test extremes done");
    n = 4 + $urandom() % 16;
    wr(TCOU_OFF_CTRL_B, 0);
    wr(TCOU_OFF_COUNT, 0);
    wr(TCOU_OFF_CMP_A, n);
    wr(TCOU_OFF_CTRL_A, 1);
    wr(TCOU_OFF_CTRL_B, 32'h49);
    repeat (100) @(posedge aclk);
    hi = 0;
    repeat (8 * n) @(posedge aclk) hi += compare_output_pin[0];
    chk("duty", 4 * n, hi);
    $display("test half duty done");
    for (int s = 1; s <= 5; s++) begin
      wr(TCOU_OFF_CTRL_B, 0);
      wr(TCOU_OFF_COUNT, 0);
      wr(TCOU_OFF_CTRL_A, $urandom() % 16);
      wr(TCOU_OFF_CTRL_B, s);
      repeat (2048) @(posedge aclk);
      wr(TCOU_OFF_CTRL_B, 0);
      rd(TCOU_OFF_COUNT, 0, 2'b00, 0);
      n = 2048 >> sh[s - 1];
      chk("tick rate", 1, 32'(v + 1 >= n && v <= n + 8));
    end
    $display("test prescaler done");
    test_done();
  end
endmodule

// ===== src/tcou_axil_regs.sv
// AXI4-Lite slave front end: one-cycle write strobe, read address passed straight through
`timescale 1ns/1ps
module tcou_axil_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d, berr_q, berr_d, rerr_q, rerr_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready = !w_q && !b_q;
  assign s_axi_arready = !r_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = berr_q ? 2'h2 : 2'h0;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rerr_q ? 2'h2 : 2'h0;
  assign wr_addr = awa_q;
  assign wr_data = wd_q;
  assign wr_strb = ws_q;
  assign wr_en = aw_q && w_q && !b_q;
  assign rd_addr = s_axi_araddr;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    berr_d = berr_q;
    r_d = r_q;
    rd_d = rd_q;
    rerr_d = rerr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_en) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      berr_d = wr_err;
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_d = 1'b1;
      rd_d = rd_data;
      rerr_d = rd_err;
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      berr_q <= 1'b0;
      rerr_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      rd_q <= 32'h0000_0000;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      berr_q <= berr_d;
      rerr_q <= rerr_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      rd_q <= rd_d;
    end
  end
endmodule

// ===== src/tcou_pkg.sv
// Package: constants and types for the timer compare output unit
// Overview of operation
// - Nonzero channel output mode replaces port output value with compare output.
// - Pin direction still follows port direction bit; output visible only when set.
// - Compare output state can be initialised before enabling it onto pin.
// - Reserved output mode encodings in some waveform modes stay undefined.
// - Output mode has no influence on input capture logic.
// - Output mode zero leaves compare output register unchanged at match.
// - New output mode applies from first compare match after the write.
// - Non-PWM force strobe applies configured action immediately.
// - Waveform mode selects counting sequence; output modes only shape pins.
// - In PWM modes output mode selects inverted or non-inverted waveform.
// - In non-PWM modes output mode selects set, clear or toggle.
// - Phase correct non-inverted: BOTTOM holds low, TOP holds high.
// - Phase correct inverted: BOTTOM and TOP levels are the opposite.
// - Mode 0x9 with channel A mode 0x1 toggles channel A, 50% duty.
// - Fully synchronous; timer tick is a clock enable only.
// - Compare value double buffered in PWM modes: copied at update point, not on write.
// - Prescaler divides by 1, 8, 64, 256 or 1024.
package tcou_pkg;
  localparam int TCOU_CNT_W = 16;
  localparam int TCOU_NCH = 2;
  // Register byte offsets
  localparam logic [7:0] TCOU_OFF_CTRL_A = 8'h00;
  localparam logic [7:0] TCOU_OFF_CTRL_B = 8'h04;
  localparam logic [7:0] TCOU_OFF_CTRL_C = 8'h08;
  localparam logic [7:0] TCOU_OFF_COUNT = 8'h0C;
  localparam logic [7:0] TCOU_OFF_CMP_A = 8'h10;
  localparam logic [7:0] TCOU_OFF_CMP_B = 8'h14;
  localparam logic [7:0] TCOU_OFF_STATUS = 8'h18;
  localparam logic [7:0] TCOU_OFF_MASK = 8'h1C;
  localparam logic [7:0] TCOU_OFF_OUTSTATE = 8'h20;
  // Field positions: ctrl_a {mode_b[3:2], mode_a[1:0]}, ctrl_b {wgm[6:3], clksel[2:0]}
  localparam int TCOU_POS_WGM = 3;
  localparam int TCOU_POS_CS = 0;
  // Status bits: match A, match B, overflow
  localparam int TCOU_ST_W = 3;
  localparam int TCOU_ST_OVF = 2;
  localparam logic [TCOU_CNT_W-1:0] TCOU_CNT_RESET = 16'h0000;
  localparam logic [TCOU_CNT_W-1:0] TCOU_CMP_RESET = 16'h0000;
  localparam logic [TCOU_CNT_W-1:0] TCOU_MAX = 16'hFFFF;
  localparam logic [TCOU_CNT_W-1:0] TCOU_TOP_8 = 16'h00FF;
  localparam logic [TCOU_CNT_W-1:0] TCOU_TOP_9 = 16'h01FF;
  localparam logic [TCOU_CNT_W-1:0] TCOU_TOP_10 = 16'h03FF;
  // Prescaler divide ratios minus one
  localparam logic [9:0] TCOU_DIV8 = 10'h007;
  localparam logic [9:0] TCOU_DIV64 = 10'h03F;
  localparam logic [9:0] TCOU_DIV256 = 10'h0FF;
  localparam logic [9:0] TCOU_DIV1024 = 10'h3FF;
  localparam logic [3:0] TCOU_WGM_PC_OCR = 4'h9;
  // Output mode encodings
  localparam logic [1:0] TCOU_COM_OFF = 2'h0;
  localparam logic [1:0] TCOU_COM_TOG = 2'h1;
  localparam logic [1:0] TCOU_COM_CLR = 2'h2;
  localparam logic [1:0] TCOU_COM_SET = 2'h3;
  typedef enum logic [1:0] {
    TCOU_SEQ_NORMAL,
    TCOU_SEQ_CTC,
    TCOU_SEQ_FAST,
    TCOU_SEQ_PHASE
  } tcou_seq_type;
endpackage

// ===== src/tcou_prescaler.sv
// Prescaler producing the one-cycle timer tick enable
`timescale 1ns/1ps
module tcou_prescaler
  import tcou_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selection: 0 stop, 1 /1, 2 /8, 3 /64, 4 /256, 5 /1024, others stop
  input wire logic [2:0] clk_select,
  // Tick
  output logic timer_tick_enable
);
  logic [9:0] div_q, div_d;
  logic [9:0] limit;

  always_comb begin
    unique case (clk_select)
      3'h2: limit = TCOU_DIV8;
      3'h3: limit = TCOU_DIV64;
      3'h4: limit = TCOU_DIV256;
      3'h5: limit = TCOU_DIV1024;
      default: limit = 10'h000;
    endcase
  end

  always_comb begin
    div_d = div_q + 10'h001;
    timer_tick_enable = 1'b0;
    if (clk_select == 3'h0 || clk_select > 3'h5) begin
      div_d = 10'h000;
    end else if (div_q >= limit) begin
      div_d = 10'h000;
      timer_tick_enable = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_d;
    end
  end
endmodule

// ===== src/tcou_top.sv
// Timer compare output unit: counter, compare channels, pin override
`timescale 1ns/1ps
module tcou_top
  import tcou_pkg::*;
#(
  parameter int NCH = TCOU_NCH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // General port pins of both channels
  input wire logic [NCH-1:0] port_out_value,
  input wire logic [NCH-1:0] compare_pin_direction_bit,
  // Pins
  output logic [NCH-1:0] compare_output_pin,
  output logic [NCH-1:0] compare_output_pin_oe,
  // Interrupt
  output logic irq
);
  logic wr_en, wr_err, rd_err;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic timer_tick_enable;

  tcou_axil_regs u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  //////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [2*NCH-1:0] timer_ctrl_a_q, timer_ctrl_a_d;
  logic [3:0] waveform_gen_mode_q, waveform_gen_mode_d;
  logic [2:0] clk_select_q, clk_select_d;
  logic [TCOU_CNT_W-1:0] buf_cmp_q [NCH];
  logic [TCOU_CNT_W-1:0] buf_cmp_d [NCH];
  logic [TCOU_CNT_W-1:0] act_cmp_q [NCH];
  logic [TCOU_CNT_W-1:0] act_cmp_d [NCH];
  logic [TCOU_ST_W-1:0] status_q, status_d, mask_q, mask_d;
  logic [NCH-1:0] force_compare_strobe;
  logic [NCH-1:0] init_wr;
  logic [NCH-1:0] init_val;
  logic cnt_wr;

  logic wr_ctrl_a, wr_ctrl_b, wr_ctrl_c, wr_cnt, wr_st, wr_mk, wr_os;
  logic [NCH-1:0] wr_cmp;
  assign wr_ctrl_a = wr_en && wr_strb[0] && wr_addr == TCOU_OFF_CTRL_A;
  assign wr_ctrl_b = wr_en && wr_strb[0] && wr_addr == TCOU_OFF_CTRL_B;
  assign wr_ctrl_c = wr_en && wr_strb[0] && wr_addr == TCOU_OFF_CTRL_C;
  assign wr_cnt = wr_en && wr_addr == TCOU_OFF_COUNT;
  assign wr_cmp[0] = wr_en && wr_addr == TCOU_OFF_CMP_A;
  assign wr_cmp[1] = wr_en && wr_addr == TCOU_OFF_CMP_B;
  assign wr_st = wr_en && wr_strb[0] && wr_addr == TCOU_OFF_STATUS;
  assign wr_mk = wr_en && wr_strb[0] && wr_addr == TCOU_OFF_MASK;
  assign wr_os = wr_en && wr_strb[0] && wr_addr == TCOU_OFF_OUTSTATE;
  assign wr_err = !(wr_addr inside {TCOU_OFF_CTRL_A, TCOU_OFF_CTRL_B, TCOU_OFF_CTRL_C,
    TCOU_OFF_COUNT, TCOU_OFF_CMP_A, TCOU_OFF_CMP_B, TCOU_OFF_STATUS, TCOU_OFF_MASK,
    TCOU_OFF_OUTSTATE});
  assign cnt_wr = wr_cnt;
  assign init_wr = wr_os ? {NCH{1'b1}} : '0;
  assign init_val = wr_data[NCH-1:0];
  assign force_compare_strobe = wr_ctrl_c ? wr_data[NCH-1:0] : '0;

  tcou_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_select(clk_select_q),
    .timer_tick_enable(timer_tick_enable)
  );

  //////////////////////////////////////////////////////////////////////
  // Counting sequence decode: the waveform mode, plus compare A as TOP in modes 0x4, 0x9, 0xB and 0xF
  tcou_seq_type seq;
  logic [TCOU_CNT_W-1:0] top;
  logic dbl_buf;
  always_comb begin
    seq = TCOU_SEQ_NORMAL;
    top = TCOU_MAX;
    dbl_buf = 1'b0;
    unique case (waveform_gen_mode_q)
      4'h1: begin seq = TCOU_SEQ_PHASE; top = TCOU_TOP_8; dbl_buf = 1'b1; end
      4'h2: begin seq = TCOU_SEQ_PHASE; top = TCOU_TOP_9; dbl_buf = 1'b1; end
      4'h3: begin seq = TCOU_SEQ_PHASE; top = TCOU_TOP_10; dbl_buf = 1'b1; end
      4'h4: begin seq = TCOU_SEQ_CTC; top = buf_cmp_q[0]; end
      4'h5: begin seq = TCOU_SEQ_FAST; top = TCOU_TOP_8; dbl_buf = 1'b1; end
      4'h6: begin seq = TCOU_SEQ_FAST; top = TCOU_TOP_9; dbl_buf = 1'b1; end
      4'h7: begin seq = TCOU_SEQ_FAST; top = TCOU_TOP_10; dbl_buf = 1'b1; end
      4'h9, 4'hB: begin seq = TCOU_SEQ_PHASE; top = act_cmp_q[0]; dbl_buf = 1'b1; end
      4'hF: begin seq = TCOU_SEQ_FAST; top = act_cmp_q[0]; dbl_buf = 1'b1; end
      default: begin seq = TCOU_SEQ_NORMAL; top = TCOU_MAX; end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Counter
  logic [TCOU_CNT_W-1:0] count_q, count_d;
  logic down_q, down_d;
  logic at_top, at_bot, update_pt, ovf;
  logic is_pwm;
  assign is_pwm = seq == TCOU_SEQ_FAST || seq == TCOU_SEQ_PHASE;
  assign at_top = count_q >= top;
  assign at_bot = count_q == TCOU_CNT_RESET;
  // Phase correct and fast PWM both update at TOP
  assign update_pt = timer_tick_enable && ((seq == TCOU_SEQ_PHASE && at_top)
    || (seq == TCOU_SEQ_FAST && at_top));
  assign ovf = timer_tick_enable && (seq == TCOU_SEQ_PHASE ? at_bot && down_q : at_top);

  always_comb begin
    count_d = count_q;
    down_d = down_q;
    if (cnt_wr) begin
      count_d = wr_data[TCOU_CNT_W-1:0];
    end else if (timer_tick_enable) begin
      if (seq == TCOU_SEQ_PHASE) begin
        if (at_top) begin
          down_d = 1'b1;
          count_d = top - 16'h0001;
        end else if (at_bot && down_q) begin
          down_d = 1'b0;
          count_d = count_q + 16'h0001;
        end else begin
          count_d = down_q ? count_q - 16'h0001 : count_q + 16'h0001;
        end
      end else begin
        count_d = at_top ? TCOU_CNT_RESET : count_q + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Per-channel compare and output action
  logic [NCH-1:0] oc_q, oc_d, match;
  logic [1:0] mode [NCH];
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign mode[c] = timer_ctrl_a_q[2*c +: 2];
      assign match[c] = timer_tick_enable && count_q == act_cmp_q[c];
      always_comb begin
        act_cmp_d[c] = act_cmp_q[c];
        if (!dbl_buf || update_pt) begin
          act_cmp_d[c] = buf_cmp_q[c];
        end
        oc_d[c] = oc_q[c];
        if (init_wr[c]) begin
          oc_d[c] = init_val[c];
        end else if (!is_pwm && (match[c] || force_compare_strobe[c])) begin
          unique case (mode[c])
            TCOU_COM_TOG: oc_d[c] = !oc_q[c];
            TCOU_COM_CLR: oc_d[c] = 1'b0;
            TCOU_COM_SET: oc_d[c] = 1'b1;
            default: oc_d[c] = oc_q[c];
          endcase
        end else if (is_pwm && timer_tick_enable) begin
          // Non-inverted clears on up-match, sets on down-match or BOTTOM
          if (c == 0 && mode[c] == TCOU_COM_TOG && waveform_gen_mode_q == TCOU_WGM_PC_OCR) begin
            if (match[c]) oc_d[c] = !oc_q[c];
          end else if (mode[c] == TCOU_COM_CLR || mode[c] == TCOU_COM_SET) begin
            // Extremes: BOTTOM stays low in fast and phase correct, TOP stays high in phase correct only (non-inverted)
            if (act_cmp_q[c] == TCOU_CNT_RESET) begin
              oc_d[c] = mode[c] == TCOU_COM_SET;
            end else if (act_cmp_q[c] >= top && seq == TCOU_SEQ_PHASE) begin
              oc_d[c] = mode[c] == TCOU_COM_CLR;
            end else if (match[c]) begin
              oc_d[c] = (seq == TCOU_SEQ_PHASE && down_q) ? mode[c] == TCOU_COM_CLR
                : mode[c] == TCOU_COM_SET;
            end else if (seq == TCOU_SEQ_FAST && at_top) begin
              oc_d[c] = mode[c] == TCOU_COM_CLR;
            end
          end
          // Toggle in other PWM modes is reserved: output left as is.
        end
      end
      // Pin mux: mode nonzero overrides port value; direction bit gates drive
      assign compare_output_pin[c] = mode[c] != TCOU_COM_OFF ? oc_q[c] : port_out_value[c];
      assign compare_output_pin_oe[c] = compare_pin_direction_bit[c];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Register writes, status and interrupt
  always_comb begin
    timer_ctrl_a_d = wr_ctrl_a ? wr_data[2*NCH-1:0] : timer_ctrl_a_q;
    waveform_gen_mode_d = wr_ctrl_b ? wr_data[TCOU_POS_WGM +: 4] : waveform_gen_mode_q;
    clk_select_d = wr_ctrl_b ? wr_data[TCOU_POS_CS +: 3] : clk_select_q;
    for (int i = 0; i < NCH; i++) begin
      buf_cmp_d[i] = wr_cmp[i] ? wr_data[TCOU_CNT_W-1:0] : buf_cmp_q[i];
    end
    mask_d = wr_mk ? wr_data[TCOU_ST_W-1:0] : mask_q;
    status_d = status_q;
    if (wr_st) begin
      status_d = status_q & ~wr_data[TCOU_ST_W-1:0];
    end
    // Set wins over a simultaneous clear
    status_d = status_d | {ovf, match[1], match[0]};
  end

  assign irq = |(status_q & mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_ctrl_a_q <= '0;
      waveform_gen_mode_q <= 4'h0;
      clk_select_q <= 3'h0;
      count_q <= TCOU_CNT_RESET;
      down_q <= 1'b0;
      oc_q <= '0;
      status_q <= '0;
      mask_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        buf_cmp_q[i] <= TCOU_CMP_RESET;
        act_cmp_q[i] <= TCOU_CMP_RESET;
      end
    end else begin
      timer_ctrl_a_q <= timer_ctrl_a_d;
      waveform_gen_mode_q <= waveform_gen_mode_d;
      clk_select_q <= clk_select_d;
      count_q <= count_d;
      down_q <= down_d;
      oc_q <= oc_d;
      status_q <= status_d;
      mask_q <= mask_d;
      for (int i = 0; i < NCH; i++) begin
        buf_cmp_q[i] <= buf_cmp_d[i];
        act_cmp_q[i] <= act_cmp_d[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux; strobe register always reads zero
  always_comb begin
    rd_err = 1'b0;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      TCOU_OFF_CTRL_A: rd_data[2*NCH-1:0] = timer_ctrl_a_q;
      TCOU_OFF_CTRL_B: rd_data[6:0] = {waveform_gen_mode_q, clk_select_q};
      TCOU_OFF_CTRL_C: rd_data = 32'h0000_0000;
      TCOU_OFF_COUNT: rd_data[TCOU_CNT_W-1:0] = count_q;
      TCOU_OFF_CMP_A: rd_data[TCOU_CNT_W-1:0] = buf_cmp_q[0];
      TCOU_OFF_CMP_B: rd_data[TCOU_CNT_W-1:0] = buf_cmp_q[1];
      TCOU_OFF_STATUS: rd_data[TCOU_ST_W-1:0] = status_q;
      TCOU_OFF_MASK: rd_data[TCOU_ST_W-1:0] = mask_q;
      TCOU_OFF_OUTSTATE: rd_data[NCH-1:0] = oc_q;
      default: rd_err = 1'b1;
    endcase
  end
  // Input capture is not part of this block, so output modes cannot reach it.
endmodule
